// ---- hdl/tccu_pkg.sv ----
// Constants, register map and bus carrier type for the timer capture/compare unit.
package tccu_pkg;

  // ==========================================================================
  // Register bus carrier
  // ==========================================================================
  localparam int unsigned TCCU_AW = 8;
  localparam int unsigned TCCU_DW = 8;

  typedef struct packed {
    logic [TCCU_AW-1:0] addr;
    logic [TCCU_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } tccu_bus_req_t;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] TCCU_OFF_CTRL     = 8'hEA;
  localparam logic [7:0] TCCU_OFF_EDGE_SEL = 8'hEB;
  localparam logic [7:0] TCCU_OFF_FLAGS    = 8'hC8;
  localparam logic [7:0] TCCU_OFF_SET_EN   = 8'hEE;
  localparam logic [7:0] TCCU_OFF_CLR_TGL  = 8'hEF;
  localparam logic [7:0] TCCU_OFF_CNT_LO   = 8'hE8;
  localparam logic [7:0] TCCU_OFF_CNT_HI   = 8'hE9;
  localparam logic [7:0] TCCU_OFF_PORT4    = 8'hC0;
  localparam logic [7:0] TCCU_OFF_CAP_BASE = 8'hA0;
  localparam logic [7:0] TCCU_OFF_CMP_BASE = 8'hB0;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int unsigned CTL_FULL_IRQ_EN = 7;
  localparam int unsigned CTL_BYTE_IRQ_EN = 6;
  localparam int unsigned CTL_EXT_RST_EN  = 5;
  localparam int unsigned CTL_BYTE_OV     = 4;
  localparam int unsigned CTL_PRESC_HI    = 3;
  localparam int unsigned CTL_PRESC_LO    = 2;
  localparam int unsigned CTL_SRC_HI      = 1;
  localparam int unsigned CTL_SRC_LO      = 0;

  localparam logic [1:0] SRC_HALT  = 2'h0;
  localparam logic [1:0] SRC_DIV12 = 2'h1;
  localparam logic [1:0] SRC_TEST  = 2'h2;
  localparam logic [1:0] SRC_PIN   = 2'h3;

  // ==========================================================================
  // Flag register fields and port bit groups
  // ==========================================================================
  localparam int unsigned FLG_FULL_OV = 7;
  localparam int unsigned FLG_CMP_LO  = 4;
  localparam int unsigned FLG_CAP_LO  = 0;
  localparam int unsigned PORT_SC_HI  = 5;
  localparam int unsigned PORT_TG_LO  = 6;

  // ==========================================================================
  // Reset values and timing
  // ==========================================================================
  localparam logic [7:0]  TCCU_REG_RST   = 8'h00;
  localparam logic [7:0]  TCCU_PORT4_RST = 8'hFF;
  localparam logic [15:0] TCCU_CNT_RST   = 16'h0000;
  localparam int unsigned SYS_DIV_RATIO  = 12;

endpackage : tccu_pkg

// ---- hdl/tccu_pin_sync.sv ----
// Two-stage synchroniser with edge detection for one external pin.
`timescale 1ns/1ns
module tccu_pin_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Pin and detected edges
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ==========================================================================
  // Synchroniser
  // ==========================================================================
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule : tccu_pin_sync

// ---- hdl/tccu_top.sv ----
// Timer/counter with prescaler, four capture registers and three compare channels.
// What this block does
// - Prescaler divides by 1, 2, 4 or 8 from a two-bit select.
// - Mode field: halt, system clock over twelve, test, or external pin.
// - Prescaler advances on a rising edge of the chosen source.
// - Prescaler clears on select change, source change or timer reset.
// - Counter has no load path; clears on reset or enabled external edge.
// - Counter bytes are read live with no snapshot.
// - Idle mode holds counter and prescaler reset and halted.
// - Enabled edge on a capture input copies the counter and flags it.
// - Edge select bit 2n enables rising, bit 2n+1 falling edges.
// - Input with no edge enabled never captures or flags.
// - Three compare registers are matched on each counter change and raise flags.
// - Set match drives bits 0-5 high, clear low, toggle inverts 6-7.
// - Simultaneous set and clear matches clear bits 0 to 5.
// - Compare registers clear to zero on reset.
// - Software port access does not disturb compare actions.
// - Byte and full overflows share one request, each separately enabled.
// - All flags hold until software clears them.
// - Per-bit set enables gate the set action on bits 0 to 5.
// - Per-bit enables gate clearing on bits 0-5 and toggling on 6-7.
// - Two read-only bits show the current level of port bits 6-7.
// - Flag register: overflow bit 7, compares 6-4, captures 3-0.
`timescale 1ns/1ns
module tccu_top #(
  parameter int unsigned NUM_CAP = 4,
  parameter int unsigned NUM_CMP = 3
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rstn,
  // Register port
  input  wire tccu_pkg::tccu_bus_req_t bus_req,
  output logic [7:0]                 rd_data_r,
  // Processor state
  input  wire logic                  idle_mode,
  // External pins
  input  wire logic                  ext_count_clock,
  input  wire logic                  ext_timer_reset_input,
  input  wire logic                  capture_input_zero,
  input  wire logic                  capture_input_one,
  input  wire logic                  capture_input_two,
  input  wire logic                  capture_input_three,
  // Outputs
  output logic [7:0]                 port4_out_r,
  output logic [7:0]                 timer_irq_flag_reg_r,
  output logic                       overflow_irq_r
);
  import tccu_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam logic [3:0] DIV12_LAST = 4'(SYS_DIV_RATIO - 1);

  logic [7:0]  timer_two_control_r;
  logic [7:0]  capture_edge_select_r;
  logic [5:0]  port_set_enable_r;
  logic [7:0]  port_clear_toggle_enable_r;
  logic [15:0] capture_timer_counter_r;
  logic [15:0] capture_reg_r [NUM_CAP];
  logic [15:0] compare_reg_r [NUM_CMP];
  logic [3:0]  div12_r;
  logic [2:0]  presc_r;
  logic [3:0]  cfg_prev_r;

  logic [NUM_CAP-1:0] cap_pin;
  logic [NUM_CAP-1:0] cap_rise;
  logic [NUM_CAP-1:0] cap_fall;
  logic [NUM_CAP-1:0] cap_hit;
  logic [NUM_CMP-1:0] cmp_hit;
  logic               clk_pin_rise;
  logic               rst_pin_rise;

  logic [1:0]  src_sel;
  logic [1:0]  presc_sel;
  logic [2:0]  presc_limit;
  logic        src_tick;
  logic        timer_clear;
  logic        presc_clear;
  logic        cnt_tick;
  logic [15:0] cnt_nxt;
  logic        cnt_changed;
  logic        byte_ov;
  logic        full_ov;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  flags_nxt;
  logic [7:0]  port4_base;
  logic [7:0]  port4_nxt;
  logic [5:0]  set_mask;
  logic [5:0]  clr_mask;
  logic [1:0]  tgl_mask;
  logic [7:0]  rd_mux;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  assign cap_pin = {capture_input_three, capture_input_two,
                    capture_input_one, capture_input_zero};

  tccu_pin_sync u_clk_sync (
    .clock  (clock),
    .rstn   (rstn),
    .pin_in (ext_count_clock),
    .rise   (clk_pin_rise),
    .fall   ()
  );

  tccu_pin_sync u_rst_sync (
    .clock  (clock),
    .rstn   (rstn),
    .pin_in (ext_timer_reset_input),
    .rise   (rst_pin_rise),
    .fall   ()
  );

  for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap_sync
    tccu_pin_sync u_cap_sync (
      .clock  (clock),
      .rstn   (rstn),
      .pin_in (cap_pin[i]),
      .rise   (cap_rise[i]),
      .fall   (cap_fall[i])
    );
    // Each input has its own rising and falling enable.
    assign cap_hit[i] = (capture_edge_select_r[2*i] & cap_rise[i])
                      | (capture_edge_select_r[2*i+1] & cap_fall[i]);
  end

  // ==========================================================================
  // Clock source and prescaler
  // ==========================================================================
  assign src_sel   = timer_two_control_r[CTL_SRC_HI:CTL_SRC_LO];
  assign presc_sel = timer_two_control_r[CTL_PRESC_HI:CTL_PRESC_LO];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div12_r <= 4'h0;
    end else if (div12_r == DIV12_LAST) begin
      div12_r <= 4'h0;
    end else begin
      div12_r <= div12_r + 4'h1;
    end
  end

  // The test mode is treated as halted.
  always_comb begin
    unique case (src_sel)
      SRC_HALT:  src_tick = 1'b0;
      SRC_DIV12: src_tick = (div12_r == DIV12_LAST);
      SRC_TEST:  src_tick = 1'b0;
      SRC_PIN:   src_tick = clk_pin_rise;
    endcase
  end

  assign presc_limit = 3'((4'h1 << presc_sel) - 4'h1);
  assign timer_clear = idle_mode
                     | (timer_two_control_r[CTL_EXT_RST_EN] & rst_pin_rise);
  assign presc_clear = timer_clear
                     | (cfg_prev_r != timer_two_control_r[CTL_PRESC_HI:CTL_SRC_LO]);
  assign cnt_tick    = src_tick & ~presc_clear & (presc_r == presc_limit);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_prev_r <= 4'h0;
    end else begin
      cfg_prev_r <= timer_two_control_r[CTL_PRESC_HI:CTL_SRC_LO];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      presc_r <= 3'h0;
    end else if (presc_clear) begin
      presc_r <= 3'h0;
    end else if (src_tick) begin
      presc_r <= (presc_r == presc_limit) ? 3'h0 : presc_r + 3'h1;
    end
  end

  // ==========================================================================
  // Counter
  // ==========================================================================
  // The counter has no software load path.
  always_comb begin
    if (timer_clear) begin
      cnt_nxt = TCCU_CNT_RST;
    end else if (cnt_tick) begin
      cnt_nxt = capture_timer_counter_r + 16'h0001;
    end else begin
      cnt_nxt = capture_timer_counter_r;
    end
  end

  assign cnt_changed = (cnt_nxt != capture_timer_counter_r);
  assign byte_ov     = cnt_tick & ~timer_clear & (&capture_timer_counter_r[7:0]);
  assign full_ov     = cnt_tick & ~timer_clear & (&capture_timer_counter_r);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      capture_timer_counter_r <= TCCU_CNT_RST;
    end else begin
      capture_timer_counter_r <= cnt_nxt;
    end
  end

  // ==========================================================================
  // Capture and compare registers
  // ==========================================================================
  for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        capture_reg_r[i] <= TCCU_CNT_RST;
      end else if (cap_hit[i]) begin
        capture_reg_r[i] <= capture_timer_counter_r;
      end
    end
  end

  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        compare_reg_r[i] <= TCCU_CNT_RST;
      end else if (bus_req.wr && bus_req.addr == TCCU_OFF_CMP_BASE + 8'(2*i)) begin
        compare_reg_r[i][7:0] <= bus_req.wdata;
      end else if (bus_req.wr && bus_req.addr == TCCU_OFF_CMP_BASE + 8'(2*i+1)) begin
        compare_reg_r[i][15:8] <= bus_req.wdata;
      end
    end
    // Fires only when the counter moves onto the compare value.
    assign cmp_hit[i] = cnt_changed & (cnt_nxt == compare_reg_r[i]);
  end

  // ==========================================================================
  // Control, edge select and enable registers
  // ==========================================================================
  always_comb begin
    ctrl_nxt = (bus_req.wr && bus_req.addr == TCCU_OFF_CTRL) ? bus_req.wdata
                                                              : timer_two_control_r;
    // A new overflow wins over a clear written in the same cycle.
    ctrl_nxt[CTL_BYTE_OV] = ctrl_nxt[CTL_BYTE_OV] | byte_ov;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_two_control_r <= TCCU_REG_RST;
    end else begin
      timer_two_control_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      capture_edge_select_r <= TCCU_REG_RST;
    end else if (bus_req.wr && bus_req.addr == TCCU_OFF_EDGE_SEL) begin
      capture_edge_select_r <= bus_req.wdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_set_enable_r <= TCCU_REG_RST[PORT_SC_HI:0];
    end else if (bus_req.wr && bus_req.addr == TCCU_OFF_SET_EN) begin
      port_set_enable_r <= bus_req.wdata[PORT_SC_HI:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_clear_toggle_enable_r <= TCCU_REG_RST;
    end else if (bus_req.wr && bus_req.addr == TCCU_OFF_CLR_TGL) begin
      port_clear_toggle_enable_r <= bus_req.wdata;
    end
  end

  // ==========================================================================
  // Flag register and overflow request
  // ==========================================================================
  always_comb begin
    flags_nxt = (bus_req.wr && bus_req.addr == TCCU_OFF_FLAGS) ? bus_req.wdata
                                                                : timer_irq_flag_reg_r;
    flags_nxt[FLG_FULL_OV] = flags_nxt[FLG_FULL_OV] | full_ov;
    flags_nxt[FLG_CMP_LO +: NUM_CMP] = flags_nxt[FLG_CMP_LO +: NUM_CMP] | cmp_hit;
    flags_nxt[FLG_CAP_LO +: NUM_CAP] = flags_nxt[FLG_CAP_LO +: NUM_CAP] | cap_hit;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_irq_flag_reg_r <= TCCU_REG_RST;
    end else begin
      timer_irq_flag_reg_r <= flags_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      overflow_irq_r <= 1'b0;
    end else begin
      overflow_irq_r <= (ctrl_nxt[CTL_BYTE_OV] & ctrl_nxt[CTL_BYTE_IRQ_EN])
                      | (flags_nxt[FLG_FULL_OV] & ctrl_nxt[CTL_FULL_IRQ_EN]);
    end
  end

  // ==========================================================================
  // Port outputs
  // ==========================================================================
  // Match actions are applied on top of any software write in the same cycle.
  assign port4_base = (bus_req.wr && bus_req.addr == TCCU_OFF_PORT4) ? bus_req.wdata
                                                                      : port4_out_r;
  assign set_mask = cmp_hit[0] ? port_set_enable_r : 6'h00;
  assign clr_mask = cmp_hit[1] ? port_clear_toggle_enable_r[PORT_SC_HI:0] : 6'h00;
  assign tgl_mask = cmp_hit[2] ? port_clear_toggle_enable_r[7:PORT_TG_LO] : 2'h0;

  always_comb begin
    port4_nxt = port4_base;
    port4_nxt[PORT_SC_HI:0] = (port4_base[PORT_SC_HI:0] | set_mask) & ~clr_mask;
    port4_nxt[7:PORT_TG_LO] = port4_base[7:PORT_TG_LO] ^ tgl_mask;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port4_out_r <= TCCU_PORT4_RST;
    end else begin
      port4_out_r <= port4_nxt;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    rd_mux = 8'h00;
    case (bus_req.addr)
      TCCU_OFF_CTRL:     rd_mux = timer_two_control_r;
      TCCU_OFF_EDGE_SEL: rd_mux = capture_edge_select_r;
      TCCU_OFF_FLAGS:    rd_mux = timer_irq_flag_reg_r;
      // The upper two bits show the current level of port bits 6-7.
      TCCU_OFF_SET_EN:   rd_mux = {port4_out_r[7:PORT_TG_LO], port_set_enable_r};
      TCCU_OFF_CLR_TGL:  rd_mux = port_clear_toggle_enable_r;
      TCCU_OFF_CNT_LO:   rd_mux = capture_timer_counter_r[7:0];
      TCCU_OFF_CNT_HI:   rd_mux = capture_timer_counter_r[15:8];
      TCCU_OFF_PORT4:    rd_mux = port4_out_r;
      default:           rd_mux = 8'h00;
    endcase
    for (int i = 0; i < NUM_CAP; i++) begin
      if (bus_req.addr == TCCU_OFF_CAP_BASE + 8'(2*i)) begin
        rd_mux = capture_reg_r[i][7:0];
      end
      if (bus_req.addr == TCCU_OFF_CAP_BASE + 8'(2*i+1)) begin
        rd_mux = capture_reg_r[i][15:8];
      end
    end
    for (int i = 0; i < NUM_CMP; i++) begin
      if (bus_req.addr == TCCU_OFF_CMP_BASE + 8'(2*i)) begin
        rd_mux = compare_reg_r[i][7:0];
      end
      if (bus_req.addr == TCCU_OFF_CMP_BASE + 8'(2*i+1)) begin
        rd_mux = compare_reg_r[i][15:8];
      end
    end
  end

  // Read data stand for exactly one cycle after the read strobe.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

endmodule : tccu_top

// ---- verification/tccu_monitor.sv ----
// Port-level checker for the timer capture/compare unit.
`timescale 1ns/1ns
module tccu_monitor
  import tccu_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // Watched ports
  input  wire tccu_pkg::tccu_bus_req_t bus_req,
  input  wire logic [7:0]              rd_data_r,
  input  wire logic                    capture_input_zero,
  input  wire logic [7:0]              port4_out_r,
  input  wire logic [7:0]              timer_irq_flag_reg_r,
  input  wire logic                    overflow_irq_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [7:0] flg;
  logic [7:0] hist_r;
  logic       port_wr;
  logic       flag_wr;
  assign flg     = timer_irq_flag_reg_r;
  assign port_wr = bus_req.wr && bus_req.addr == TCCU_OFF_PORT4;
  assign flag_wr = bus_req.wr && bus_req.addr == TCCU_OFF_FLAGS;
  // Recent history of capture pin zero, long enough to span the synchroniser.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) hist_r <= 8'h00;
    else hist_r <= {hist_r[6:0], capture_input_zero};
  end
  property p_flag_hold;
    !flag_wr |=> (flg & $past(flg)) == $past(flg);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without write");
  property p_port_cause;
    $changed(port4_out_r[5:0]) && !$past(port_wr) |-> flg[5:4] != 2'h0;
  endproperty
  a_port_cause: assert property (p_port_cause) else $error("port moved without match");
  property p_tgl_cause;
    $changed(port4_out_r[7:6]) && !$past(port_wr) |-> flg[6];
  endproperty
  a_tgl_cause: assert property (p_tgl_cause) else $error("toggle without match");
  property p_set_up;
    $rose(flg[4]) && !flg[5] && !$past(port_wr)
      |-> (~port4_out_r[5:0] & $past(port4_out_r[5:0])) == 6'h00;
  endproperty
  a_set_up: assert property (p_set_up) else $error("set match lowered a bit");
  property p_clr_down;
    $rose(flg[5]) && !flg[4] && !$past(port_wr)
      |-> (port4_out_r[5:0] & ~$past(port4_out_r[5:0])) == 6'h00;
  endproperty
  a_clr_down: assert property (p_clr_down) else $error("clear match raised a bit");
  property p_ste_rd;
    bus_req.rd && bus_req.addr == TCCU_OFF_SET_EN |=> rd_data_r[7:6] == $past(port4_out_r[7:6]);
  endproperty
  a_ste_rd: assert property (p_ste_rd) else $error("toggle level bits wrong");
  property p_cap_cause;
    $rose(flg[0]) && !$past(flag_wr) |-> hist_r != 8'h00 && hist_r != 8'hFF;
  endproperty
  a_cap_cause: assert property (p_cap_cause) else $error("capture flag without edge");
  property p_rd_quiet;
    !bus_req.rd |=> rd_data_r == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  c_cap: cover property ($rose(flg[0]));
  c_tgl: cover property ($changed(port4_out_r[7]));
  c_ovf: cover property ($rose(overflow_irq_r));
endmodule : tccu_monitor

bind tccu_top tccu_monitor tccu_monitor_inst (.clock, .rstn, .bus_req, .rd_data_r,
  .capture_input_zero, .port4_out_r, .timer_irq_flag_reg_r, .overflow_irq_r);

// ---- verification/tccu_pin_src.sv ----
// Model of the external count-clock source driving the timer pin.
`timescale 1ns/1ns
module tccu_pin_src (
  // Clock and control
  input  wire logic clock,
  input  wire logic run,
  // Pin
  output logic      ext_count_clock
);
  logic [3:0] phase_r;
  // One pin period spans twelve system clocks, the fastest the pin may run.
  always_ff @(posedge clock) begin
    phase_r <= (!run || phase_r == 4'hB) ? 4'h0 : phase_r + 4'h1;
  end
  // The pin stands low whenever the source is stopped.
  assign ext_count_clock = run && (phase_r < 4'h6);
endmodule : tccu_pin_src

// ---- verification/tccu_top_tb.sv ----
// Self-checking bench for the timer capture/compare unit.
`timescale 1ns/1ns
module tccu_top_tb;
  import tccu_pkg::*;
  logic          clock, rstn, idle_mode, run, ext_rst, ext_clk, overflow_irq_r;
  logic [3:0]    cap;
  logic [7:0]    rd_data_r, port4_out_r, flags;
  tccu_bus_req_t bus_req;
  int            n_errors, tests_run;
  tccu_top tccu_top_inst (.clock, .rstn, .bus_req, .rd_data_r, .idle_mode,
    .ext_count_clock(ext_clk), .ext_timer_reset_input(ext_rst),
    .capture_input_zero(cap[0]), .capture_input_one(cap[1]), .capture_input_two(cap[2]),
    .capture_input_three(cap[3]), .port4_out_r, .timer_irq_flag_reg_r(flags), .overflow_irq_r);
  tccu_pin_src tccu_pin_src_inst (.clock, .run, .ext_count_clock(ext_clk));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= {a, d, 2'b10};
    @(posedge clock);
    bus_req <= '0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clock);
    bus_req <= {a, 8'h00, 2'b01};
    @(posedge clock);
    bus_req <= '0;
    #1 chk(rd_data_r & m, e);
  endtask : rdc
  // Sends n pin pulses, then lets the synchroniser settle.
  task automatic pulse(input int n);
    @(posedge clock) run <= 1'b1;
    repeat (12 * n) @(posedge clock);
    run <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulse
  task automatic zero;
    @(posedge clock) idle_mode <= 1'b1;
    repeat (2) @(posedge clock);
    idle_mode <= 1'b0;
  endtask : zero
  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // Clock, watchdog and test sequence
  // ==========================================================================
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    idle_mode = 1'b0;
    run = 1'b0;
    ext_rst = 1'b0;
    cap = 4'h0;
    bus_req = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rdc(TCCU_OFF_PORT4, TCCU_PORT4_RST);
    rdc(TCCU_OFF_CMP_BASE + 8'h05, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(TCCU_OFF_CTRL, {4'h0, 2'(p), SRC_PIN});
      zero();
      pulse(8);
      rdc(TCCU_OFF_CNT_LO, 8'(8 >> p));
    end
    wr(TCCU_OFF_CTRL, 8'h07);
    zero();
    pulse(1);
    wr(TCCU_OFF_CTRL, 8'h0B);
    wr(TCCU_OFF_CTRL, 8'h07);
    pulse(1);
    rdc(TCCU_OFF_CNT_LO, 8'h00);
    for (int m = 0; m < 3; m += 2) begin
      wr(TCCU_OFF_CTRL, {6'h00, 2'(m)});
      pulse(2);
      rdc(TCCU_OFF_CNT_LO, 8'h00);
    end
    wr(TCCU_OFF_CTRL, {6'h00, SRC_DIV12});
    repeat (126) @(posedge clock);
    rdc(TCCU_OFF_CNT_LO, 8'h0A, 8'hFE);
    @(posedge clock) idle_mode <= 1'b1;
    rdc(TCCU_OFF_CNT_LO, 8'h00);
    wr(TCCU_OFF_CTRL, 8'h03);
    @(posedge clock) idle_mode <= 1'b0;
    pulse(3);
    @(posedge clock) ext_rst <= 1'b1;
    repeat (6) @(posedge clock);
    rdc(TCCU_OFF_CNT_LO, 8'h03);
    @(posedge clock) ext_rst <= 1'b0;
    wr(TCCU_OFF_CTRL, 8'h23);
    @(posedge clock) ext_rst <= 1'b1;
    repeat (6) @(posedge clock);
    rdc(TCCU_OFF_CNT_LO, 8'h00);
    @(posedge clock) ext_rst <= 1'b0;
    pulse(5);
    wr(TCCU_OFF_FLAGS, 8'h00);
    // Falling-edge enable only: the rise is ignored, the fall captures.
    for (int n = 0; n < 4; n++) begin
      wr(TCCU_OFF_EDGE_SEL, 8'(2 << (2 * n)));
      @(posedge clock) cap[n] <= 1'b1;
      repeat (6) @(posedge clock);
      rdc(TCCU_OFF_FLAGS, 8'h00);
      @(posedge clock) cap[n] <= 1'b0;
      repeat (12) @(posedge clock);
      rdc(TCCU_OFF_FLAGS, 8'(1 << n));
      rdc(8'(TCCU_OFF_CAP_BASE + 2 * n), 8'h05);
      wr(TCCU_OFF_FLAGS, 8'h00);
    end
    // Rising-edge enable only: the rise on input zero captures.
    wr(TCCU_OFF_EDGE_SEL, 8'h01);
    @(posedge clock) cap[0] <= 1'b1;
    repeat (6) @(posedge clock);
    rdc(TCCU_OFF_FLAGS, 8'h01);
    wr(TCCU_OFF_FLAGS, 8'h00);
    wr(TCCU_OFF_EDGE_SEL, 8'h00);
    @(posedge clock) cap <= 4'hF;
    repeat (6) @(posedge clock);
    @(posedge clock) cap <= 4'h0;
    repeat (6) @(posedge clock);
    rdc(TCCU_OFF_FLAGS, 8'h00);
    wr(TCCU_OFF_CMP_BASE, 8'h03);
    wr(TCCU_OFF_CMP_BASE + 8'h02, 8'h05);
    wr(TCCU_OFF_CMP_BASE + 8'h04, 8'h04);
    wr(TCCU_OFF_SET_EN, 8'h15);
    wr(TCCU_OFF_CLR_TGL, 8'h83);
    wr(TCCU_OFF_PORT4, 8'h00);
    zero();
    wr(TCCU_OFF_FLAGS, 8'h00);
    pulse(3);
    rdc(TCCU_OFF_PORT4, 8'h15);
    pulse(1);
    rdc(TCCU_OFF_PORT4, 8'h95);
    rdc(TCCU_OFF_SET_EN, 8'h95);
    rdc(TCCU_OFF_FLAGS, 8'h50);
    // Drop the set flag so that the clear match alone raises its own flag.
    wr(TCCU_OFF_FLAGS, 8'h40);
    pulse(1);
    rdc(TCCU_OFF_PORT4, 8'h94);
    rdc(TCCU_OFF_FLAGS, 8'h60);
    wr(TCCU_OFF_CMP_BASE, 8'h07);
    wr(TCCU_OFF_CMP_BASE + 8'h02, 8'h07);
    wr(TCCU_OFF_PORT4, 8'h03);
    pulse(2);
    rdc(TCCU_OFF_PORT4, 8'h14);
    chk(port4_out_r, 8'h14);
    wr(TCCU_OFF_FLAGS, 8'h00);
    repeat (8) @(posedge clock);
    rdc(TCCU_OFF_FLAGS, 8'h00);
    chk(flags, 8'h00);
    wr(TCCU_OFF_CTRL, 8'h43);
    zero();
    pulse(256);
    rdc(TCCU_OFF_CTRL, 8'h53);
    rdc(TCCU_OFF_CNT_HI, 8'h01);
    chk({7'h00, overflow_irq_r}, 8'h01);
    wr(TCCU_OFF_CTRL, 8'h03);
    repeat (2) @(posedge clock);
    chk({7'h00, overflow_irq_r}, 8'h00);
    report_and_stop();
  end
endmodule : tccu_top_tb
